// >>> frame_options.sv
`timescale 1ns/1ps
//
// Summary of operation
// RULE_01: Tx parity suppressed when no-tx-parity bit set.
// RULE_02: Host then transmits only without CRC.
// RULE_03: Rx raw stream, no parity/CRC checks.
// RULE_04: Host clears rx parity bit outside type A.
// RULE_05: Transport mode prepends F0 and length bytes.
// RULE_06: Transport mode drops received leading F0.
// RULE_07: Pulse width field counts carrier periods.
// RULE_08: Lowest rate: 35 base, 27 to 42.
// RULE_09: Higher rates 18/9/5 base; gaps unsupported.
// RULE_10: Host sets anticollision bit for split frames.
// RULE_11: Extra guard time 0 to 6 etu.
// RULE_12: SOF low part 10 or 11 etu.
// RULE_13: SOF high part 2 or 3 etu.
// RULE_14: EOF low part 10 or 11 etu.
// RULE_15: Mid bit forces midrange SOF and EOF.
// RULE_16: Rx omit: fixed SOF, no EOF, last byte.
// RULE_17: Host uses stream mode for tx omission.
// RULE_18: Settings clear at reset and set-default.
// RULE_19: Tx bit rate chooses pulse width column.
// RULE_20: New settings apply from next frame.
//
module frame_options #(
    parameter int ETU_DIV = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic set_default,
    input wire logic frame_start,
    input wire logic frame_end,
    input wire logic tx_byte_valid,
    input wire logic [7:0] tx_byte,
    input wire logic [7:0] tx_length,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_first_byte,
    input wire logic rx_last_full,
    output logic [7:0] read_data,
    output logic tx_parity_en,
    output logic rx_check_en,
    output logic anticoll_frame,
    output logic [5:0] pulse_width,
    output logic pulse_supported,
    output logic [3:0] sof_low_etu,
    output logic [3:0] sof_high_etu,
    output logic [3:0] eof_etu,
    output logic rx_eof_detect,
    output logic guard_busy,
    output logic tx_out_valid,
    output logic [7:0] tx_out_byte,
    output logic fifo_write,
    output logic [7:0] fifo_data
);
    initial begin
        if (ETU_DIV < 2 || ETU_DIV > 4096) begin
            $error("ETU_DIV out of range");
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [7:0] type_a_q;
    logic [7:0] type_b_q;
    logic [7:0] bitrate_q;
    logic [7:0] act_a_q;
    logic [7:0] act_b_q;
    logic [1:0] act_rate_q;
    logic in_frame_q;

    // Power-up and set-default both return the settings to zero.
    always_ff @(posedge clock) begin
        if (reset || set_default) begin
            type_a_q <= frame_opts_pkg::SETTINGS_RESET; // RULE_18
            type_b_q <= frame_opts_pkg::SETTINGS_RESET; // RULE_18
            bitrate_q <= frame_opts_pkg::SETTINGS_RESET;
        end else if (write_strobe) begin
            if (address == frame_opts_pkg::TYPE_A_ADDR) begin
                type_a_q <= write_data;
            end
            if (address == frame_opts_pkg::TYPE_B_ADDR) begin
                type_b_q <= write_data;
            end
            if (address == frame_opts_pkg::BITRATE_ADDR) begin
                bitrate_q <= write_data;
            end
        end
    end

    // Settings are latched only at frame start so a write cannot tear a frame.
    always_ff @(posedge clock) begin
        if (reset || set_default) begin
            act_a_q <= frame_opts_pkg::SETTINGS_RESET;
            act_b_q <= frame_opts_pkg::SETTINGS_RESET;
            act_rate_q <= 2'h0;
        end else if (frame_start && !in_frame_q) begin
            act_a_q <= type_a_q; // RULE_20
            act_b_q <= type_b_q; // RULE_20
            act_rate_q <= bitrate_q[5:4]; // RULE_19
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            in_frame_q <= 1'b0;
        end else if (frame_start) begin
            in_frame_q <= 1'b1;
        end else if (frame_end) begin
            in_frame_q <= 1'b0;
        end
    end

    // Unmapped addresses read as zero; status shows the block's own state.
    always_ff @(posedge clock) begin
        if (reset) begin
            read_data <= 8'h00;
        end else if (read_strobe) begin
            unique case (address)
                frame_opts_pkg::TYPE_A_ADDR: read_data <= type_a_q;
                frame_opts_pkg::TYPE_B_ADDR: read_data <= type_b_q;
                frame_opts_pkg::BITRATE_ADDR: read_data <= bitrate_q;
                frame_opts_pkg::STATUS_ADDR: read_data <= {5'h00, guard_busy,
                    pulse_supported, in_frame_q};
                default: read_data <= 8'h00;
            endcase
        end else begin
            read_data <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Type A options
    // ------------------------------------------------------------
    logic [5:0] pw_d;
    logic pw_ok_d;
    logic transport_on;
    logic raw_rx;

    assign transport_on = act_a_q[frame_opts_pkg::A_TRANSPORT_BIT];
    assign raw_rx = act_a_q[frame_opts_pkg::A_NO_RX_PAR_BIT];

    pulse_width_lut u_lut (
        .code(act_a_q[frame_opts_pkg::A_PLEN_LSB +: 4]),
        .rate(act_rate_q),
        .width(pw_d),
        .supported(pw_ok_d)
    );

    // The parity, check and pulse controls are registered straight from active settings.
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_parity_en <= 1'b1;
            rx_check_en <= 1'b1;
            anticoll_frame <= 1'b0;
            pulse_width <= frame_opts_pkg::PULSE_BASE_128;
            pulse_supported <= 1'b1;
        end else begin
            tx_parity_en <= !act_a_q[frame_opts_pkg::A_NO_TX_PAR_BIT]; // RULE_01
            rx_check_en <= !raw_rx; // RULE_03
            anticoll_frame <= act_a_q[frame_opts_pkg::A_ANTICOLL_BIT];
            pulse_width <= pw_d; // RULE_07
            pulse_supported <= pw_ok_d; // RULE_09
        end
    end

    // Transmit side: in transport mode the start and length bytes go first.
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_LEN,
        TX_DATA
    } tx_state_t;
    tx_state_t tx_state_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            tx_state_q <= TX_IDLE;
            tx_out_valid <= 1'b0;
            tx_out_byte <= 8'h00;
        end else begin
            tx_out_valid <= 1'b0;
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (frame_start) begin
                        tx_state_q <= type_a_q[frame_opts_pkg::A_TRANSPORT_BIT] ?
                            TX_START : TX_DATA;
                    end
                end
                TX_START: begin
                    tx_out_valid <= 1'b1;
                    tx_out_byte <= frame_opts_pkg::TRANSPORT_START_BYTE; // RULE_05
                    tx_state_q <= TX_LEN;
                end
                TX_LEN: begin
                    tx_out_valid <= 1'b1;
                    tx_out_byte <= tx_length; // RULE_05
                    tx_state_q <= TX_DATA;
                end
                TX_DATA: begin
                    if (tx_byte_valid) begin
                        tx_out_valid <= 1'b1;
                        tx_out_byte <= tx_byte;
                    end
                    if (frame_end) begin
                        tx_state_q <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive side: the leading start byte never reaches the FIFO in transport mode.
    logic rx_keep;
    logic omit_rx;

    assign omit_rx = act_b_q[frame_opts_pkg::B_RX_OMIT_BIT];

    always_comb begin
        rx_keep = rx_byte_valid;
        if (transport_on && rx_first_byte &&
                rx_byte == frame_opts_pkg::TRANSPORT_START_BYTE) begin
            rx_keep = 1'b0; // RULE_06
        end
        if (omit_rx && !rx_last_full) begin
            rx_keep = 1'b0; // RULE_16
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            fifo_write <= 1'b0;
            fifo_data <= 8'h00;
        end else begin
            fifo_write <= rx_keep;
            if (rx_keep) begin
                fifo_data <= rx_byte; // RULE_03
            end
        end
    end

    // ------------------------------------------------------------
    // Type B options
    // ------------------------------------------------------------
    logic [3:0] sof_low_d;
    logic [3:0] sof_high_d;
    logic [3:0] eof_d;
    logic [3:0] egt_d;

    // Mid mode overrides the individual lengths; the table gives 10.5/2.5 style midpoints
    // which whole etu cannot show, so the long SOF low, short SOF high and short EOF values are used.
    always_comb begin
        sof_low_d = act_b_q[frame_opts_pkg::B_SOF_LOW_BIT] ?
            frame_opts_pkg::SOF_LOW_LONG_ETU : frame_opts_pkg::SOF_LOW_SHORT_ETU; // RULE_12
        sof_high_d = act_b_q[frame_opts_pkg::B_SOF_HIGH_BIT] ?
            frame_opts_pkg::SOF_HIGH_LONG_ETU : frame_opts_pkg::SOF_HIGH_SHORT_ETU; // RULE_13
        eof_d = act_b_q[frame_opts_pkg::B_EOF_BIT] ?
            frame_opts_pkg::EOF_LONG_ETU : frame_opts_pkg::EOF_SHORT_ETU; // RULE_14
        if (act_b_q[frame_opts_pkg::B_MID_BIT]) begin
            sof_low_d = frame_opts_pkg::SOF_LOW_LONG_ETU; // RULE_15
            sof_high_d = frame_opts_pkg::SOF_HIGH_SHORT_ETU; // RULE_15
            eof_d = frame_opts_pkg::EOF_SHORT_ETU; // RULE_15
        end
        egt_d = {1'b0, act_b_q[frame_opts_pkg::B_EGT_LSB +: 3]};
        if (egt_d > frame_opts_pkg::EGT_MAX_ETU) begin
            egt_d = frame_opts_pkg::EGT_MAX_ETU; // RULE_11
        end
    end

    // The receiver's SOF expectation is fixed while omission is on.
    always_ff @(posedge clock) begin
        if (reset) begin
            sof_low_etu <= frame_opts_pkg::SOF_LOW_SHORT_ETU;
            sof_high_etu <= frame_opts_pkg::SOF_HIGH_SHORT_ETU;
            eof_etu <= frame_opts_pkg::EOF_SHORT_ETU;
            rx_eof_detect <= 1'b1;
        end else begin
            sof_low_etu <= omit_rx ? frame_opts_pkg::SOF_LOW_SHORT_ETU : sof_low_d; // RULE_16
            sof_high_etu <= omit_rx ? frame_opts_pkg::SOF_HIGH_SHORT_ETU : sof_high_d;
            eof_etu <= eof_d;
            rx_eof_detect <= !omit_rx; // RULE_16
        end
    end

    // Guard time after each transmitted byte, counted on a divided etu enable.
    logic [11:0] div_q;
    logic etu_tick;
    logic guard_done;

    always_ff @(posedge clock) begin
        if (reset || div_q == 12'(ETU_DIV - 1)) begin
            div_q <= 12'h000;
        end else begin
            div_q <= div_q + 12'h001;
        end
    end

    assign etu_tick = (div_q == 12'(ETU_DIV - 1));

    etu_timer u_guard (
        .clock(clock),
        .reset(reset),
        .etu_tick(etu_tick),
        .load(tx_out_valid),
        .length(egt_d),
        .done(guard_done)
    );

    always_ff @(posedge clock) begin
        if (reset) begin
            guard_busy <= 1'b0;
        end else begin
            guard_busy <= !guard_done; // RULE_11
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_default_clears: assert property (@(posedge clock) disable iff (reset)
        set_default |=> type_a_q == 8'h00 && type_b_q == 8'h00) // RULE_18
        else $error("set default did not clear settings");
    a_tx_parity: assert property (@(posedge clock) disable iff (reset)
        act_a_q[7] |=> !tx_parity_en) // RULE_01
        else $error("parity not suppressed");
    a_rx_raw: assert property (@(posedge clock) disable iff (reset)
        act_a_q[6] |=> !rx_check_en) // RULE_03
        else $error("rx checks not disabled");
    a_start_byte: assert property (@(posedge clock) disable iff (reset)
        tx_state_q == TX_START |=> tx_out_valid && tx_out_byte == 8'hF0) // RULE_05
        else $error("start byte missing");
    a_drop_f0: assert property (@(posedge clock) disable iff (reset)
        transport_on && rx_first_byte && rx_byte == 8'hF0 |=> !fifo_write) // RULE_06
        else $error("start byte stored");
    a_base_width: assert property (@(posedge clock) disable iff (reset)
        act_a_q[4:1] == 4'h0 && act_rate_q == 2'h0 && $stable(act_a_q)
        |=> pulse_width == 6'd35) // RULE_08
        else $error("base pulse width wrong");
    a_mid_sof: assert property (@(posedge clock) disable iff (reset)
        act_b_q[1] && !act_b_q[0] |=> sof_high_etu == 4'h2 && eof_etu == 4'hA) // RULE_15
        else $error("mid mode lengths wrong");
    a_omit_eof: assert property (@(posedge clock) disable iff (reset)
        act_b_q[0] |=> !rx_eof_detect && sof_low_etu == 4'hA) // RULE_16
        else $error("omission not applied");
    a_frame_hold: assert property (@(posedge clock) disable iff (reset || set_default)
        in_frame_q && !frame_start |=> $stable(act_a_q)) // RULE_20
        else $error("settings changed mid frame");

    c_transport: cover property (@(posedge clock) tx_state_q == TX_LEN);
    c_guard: cover property (@(posedge clock) guard_busy);
    c_unsupported: cover property (@(posedge clock) !pulse_supported);
endmodule

// >>> frame_opts_pkg.sv
package frame_opts_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] TYPE_A_ADDR = 8'h05;
    localparam logic [7:0] TYPE_B_ADDR = 8'h06;
    localparam logic [7:0] BITRATE_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h20;
    localparam logic [7:0] SETTINGS_RESET = 8'h00;

    // ------------------------------------------------------------
    // Type A field positions
    // ------------------------------------------------------------
    localparam int A_NO_TX_PAR_BIT = 7;
    localparam int A_NO_RX_PAR_BIT = 6;
    localparam int A_TRANSPORT_BIT = 5;
    localparam int A_PLEN_LSB = 1;
    localparam int A_ANTICOLL_BIT = 0;

    // ------------------------------------------------------------
    // Type B field positions
    // ------------------------------------------------------------
    localparam int B_EGT_LSB = 5;
    localparam int B_SOF_LOW_BIT = 4;
    localparam int B_SOF_HIGH_BIT = 3;
    localparam int B_EOF_BIT = 2;
    localparam int B_MID_BIT = 1;
    localparam int B_RX_OMIT_BIT = 0;

    // ------------------------------------------------------------
    // Protocol constants, times in etu or carrier periods
    // ------------------------------------------------------------
    localparam logic [7:0] TRANSPORT_START_BYTE = 8'hF0;
    localparam logic [3:0] EGT_MAX_ETU = 4'h6;
    localparam logic [3:0] SOF_LOW_SHORT_ETU = 4'hA;
    localparam logic [3:0] SOF_LOW_LONG_ETU = 4'hB;
    localparam logic [3:0] SOF_HIGH_SHORT_ETU = 4'h2;
    localparam logic [3:0] SOF_HIGH_LONG_ETU = 4'h3;
    localparam logic [3:0] EOF_SHORT_ETU = 4'hA;
    localparam logic [3:0] EOF_LONG_ETU = 4'hB;
    localparam logic [5:0] PULSE_BASE_128 = 6'h23;
    localparam logic [5:0] PULSE_BASE_64 = 6'h12;
    localparam logic [5:0] PULSE_BASE_32 = 6'h09;
    localparam logic [5:0] PULSE_BASE_16 = 6'h05;

    typedef enum logic [1:0] {
        RATE_128,
        RATE_64,
        RATE_32,
        RATE_16
    } tx_rate_t;

endpackage

// >>> pulse_width_lut.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Type A modulation pulse width lookup
// ------------------------------------------------------------
module pulse_width_lut (
    input wire logic [3:0] code,
    input wire logic [1:0] rate,
    output logic [5:0] width,
    output logic supported
);
    logic signed [4:0] offset;
    logic [5:0] base;
    logic signed [4:0] lo;
    logic signed [4:0] hi;

    // The code is a signed offset around the per-rate base width.
    always_comb begin
        offset = {code[3], code}; // RULE_08
        unique case (rate) // RULE_19
            2'h0: begin
                base = frame_opts_pkg::PULSE_BASE_128;
                lo = -5'sd8;
                hi = 5'sd7;
            end
            2'h1: begin
                base = frame_opts_pkg::PULSE_BASE_64;
                lo = -5'sd6;
                hi = 5'sd6;
            end
            2'h2: begin
                base = frame_opts_pkg::PULSE_BASE_32;
                lo = -5'sd4;
                hi = 5'sd4;
            end
            2'h3: begin
                base = frame_opts_pkg::PULSE_BASE_16;
                lo = -5'sd3;
                hi = 5'sd3;
            end
        endcase
        // Rows 0100..0110 at the double rate run backwards, an oddity kept exactly.
        width = 6'(base + 6'(offset)); // RULE_07
        if (rate == 2'h1 && code == 4'h5) begin
            width = 6'h15;
        end
        if (rate == 2'h1 && code == 4'h6) begin
            width = 6'h14;
        end
        if (rate == 2'h1 && code == 4'h4) begin
            width = 6'h16;
        end
        supported = (offset >= lo) && (offset <= hi); // RULE_09
    end
endmodule

// >>> etu_timer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Counts a run of etu from the one-cycle etu enable
// ------------------------------------------------------------
module etu_timer (
    input wire logic clock,
    input wire logic reset,
    input wire logic etu_tick,
    input wire logic load,
    input wire logic [3:0] length,
    output logic done
);
    logic [3:0] left_q;

    // A zero length is done at once, in the load cycle itself, so a zero guard time costs nothing.
    always_ff @(posedge clock) begin
        if (reset || load) begin
            left_q <= reset ? 4'h0 : length;
        end else if (etu_tick && left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end

    assign done = (left_q == 4'h0) && !(load && length != 4'h0);
endmodule

// >>> card_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Card side of the field: hears transmitted bytes, returns bytes
// ------------------------------------------------------------
module card_model (
    input wire logic clock,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_byte,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_first_byte,
    output logic rx_last_full
);
    logic [7:0] heard[$];

    // Every byte put on the field is queued so the bench can check order and value.
    always @(posedge clock) begin
        if (tx_out_valid === 1'b1) begin
            heard.push_back(tx_out_byte);
        end
    end

    initial begin
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        rx_first_byte = 1'b0;
        rx_last_full = 1'b0;
    end

    // Outside the strobe the lines show the inverse, so a stale byte is never mistaken.
    task automatic send(input logic [7:0] b, input logic first, input logic last);
        @(posedge clock);
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        rx_first_byte <= first;
        rx_last_full <= last;
        @(posedge clock);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
        rx_first_byte <= ~first;
        rx_last_full <= ~last;
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the frame options block
// ------------------------------------------------------------
module testbench;
    localparam int D = 4;
    logic clock, reset, write_strobe, read_strobe, set_default, frame_start, frame_end;
    logic tx_byte_valid;
    logic [7:0] address, write_data, tx_byte, tx_length, read_data, tx_out_byte, fifo_data;
    logic rx_byte_valid, rx_first_byte, rx_last_full, tx_parity_en, rx_check_en;
    logic anticoll_frame, pulse_supported, rx_eof_detect, guard_busy, tx_out_valid, fifo_write;
    logic [7:0] rx_byte;
    logic [5:0] pulse_width;
    logic [3:0] sof_low_etu, sof_high_etu, eof_etu;
    logic [7:0] fifo_q[$];
    int miscompares = 0;
    int samples_checked = 0;

    frame_options #(.ETU_DIV(D)) dut (.*);
    card_model card (.*);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Bytes the receiver stores are collected in order.
    always @(posedge clock) begin
        if (fifo_write === 1'b1) begin
            fifo_q.push_back(fifo_data);
        end
    end

    // ------------------------------------------------------------
    // Expectations and checks
    // ------------------------------------------------------------
    // Returns {supported, width}; double rate codes 4 to 6 fall back down again.
    function automatic logic [6:0] exp_pulse(input logic [3:0] c, input logic [1:0] r);
        int s;
        int w;
        logic ok;
        s = $signed(c);
        case (r)
            2'h0: begin w = 35 + s; ok = 1'b1; end
            2'h1: begin w = (s > 3) ? 26 - s : 18 + s; ok = (s >= -6) && (s <= 6); end
            2'h2: begin w = 9 + s; ok = (s >= -4) && (s <= 4); end
            default: begin w = 5 + s; ok = (s >= -3) && (s <= 3); end
        endcase
        return {ok, 6'(w)};
    endfunction

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int lo, input int hi, input string m);
        samples_checked++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: %s count %0d outside %0d..%0d", $time, m, got, lo, hi);
        end
    endtask

    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus and frame drivers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 d = read_data;
    endtask

    // Waits long enough that transport mode may take payload right after.
    task automatic start_frame();
        @(posedge clock);
        frame_start <= 1'b1;
        @(posedge clock);
        frame_start <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic end_frame();
        @(posedge clock);
        frame_end <= 1'b1;
        @(posedge clock);
        frame_end <= 1'b0;
    endtask

    task automatic send_tx(input logic [7:0] b);
        @(posedge clock);
        tx_byte_valid <= 1'b1;
        tx_byte <= b;
        @(posedge clock);
        tx_byte_valid <= 1'b0;
        tx_byte <= ~b;
    endtask

    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v, a, b, t;
        logic [6:0] e;
        int n, g;
        reset = 1'b1;
        {write_strobe, read_strobe, set_default, frame_start, frame_end} = 5'h00;
        {address, write_data, tx_byte, tx_length} = 32'h00000000;
        tx_byte_valid = 1'b0;
        n = $urandom(78);
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        #1;
        check_val({tx_parity_en, rx_check_en, rx_eof_detect, anticoll_frame}, 8'h0E, "rst");
        check_val({sof_low_etu, sof_high_etu}, 8'hA2, "rst sof");
        check_val(8'(pulse_width), 8'h23, "rst pw");
        rd(8'h05, v); check_val(v, 8'h00, "rst a");
        rd(8'h06, v); check_val(v, 8'h00, "rst b");
        rd(8'h3F, v); check_val(v, 8'h00, "unmapped");
        // Every pulse code at every transmit rate, other type A bits random except the transport bit, held at zero.
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 16; c++) begin
                v = 8'($urandom);
                a = {v[7:6], 1'b0, 4'(c), v[0]};
                wr(8'h04, {2'h0, 2'(r), 4'h0});
                wr(8'h05, a);
                rd(8'h05, v); check_val(v, a, "rw a");
                start_frame();
                e = exp_pulse(4'(c), 2'(r));
                check_val(8'(tx_parity_en), 8'(!a[7]), "txpar");
                check_val(8'(rx_check_en), 8'(!a[6]), "rxchk");
                check_val(8'(anticoll_frame), 8'(a[0]), "acoll");
                check_val(8'(pulse_supported), 8'(e[6]), "psup");
                if (e[6]) check_val(8'(pulse_width), {2'h0, e[5:0]}, "pw");
                end_frame();
            end
        end
        // A write in mid-frame and a repeated start must not disturb the running frame.
        wr(8'h05, 8'h00);
        start_frame();
        wr(8'h05, 8'h80);
        start_frame();
        check_val(8'(tx_parity_en), 8'h01, "midframe");
        end_frame();
        start_frame();
        check_val(8'(tx_parity_en), 8'h00, "nextframe");
        end_frame();
        // Type B lengths: corners then random values.
        for (int i = 0; i < 20; i++) begin
            b = (i == 0) ? 8'h1C : (i == 1) ? 8'h1E : 8'($urandom);
            wr(8'h06, b);
            start_frame();
            t = b[0] ? 8'hA2 : b[1] ? 8'hB2 : {b[4] ? 4'hB : 4'hA, b[3] ? 4'h3 : 4'h2};
            check_val({sof_low_etu, sof_high_etu}, t, "sof");
            check_val(8'(eof_etu), (b[2] && !b[1]) ? 8'h0B : 8'h0A, "eof");
            check_val(8'(rx_eof_detect), 8'(!b[0]), "eofdet");
            end_frame();
        end
        // Extra guard time after a transmitted byte, including the top code.
        wr(8'h05, 8'h00);
        for (int k = 0; k < 4; k++) begin
            g = k * 3 - k / 3 * 2;
            wr(8'h06, {3'(g), 5'h00});
            start_frame();
            card.heard.delete();
            t = 8'($urandom);
            send_tx(t);
            n = 0;
            repeat (48) begin
                @(posedge clock);
                if (guard_busy === 1'b1) n++;
            end
            g = (g > 6) ? 6 : g;
            check_count(n, (g == 0) ? 0 : g * D - D + 1, (g == 0) ? 0 : g * D + 1, "egt");
            check_val(card.heard[0], t, "echo");
            end_frame();
        end
        // Transport frame bytes on transmit and the dropped start byte on receive.
        wr(8'h06, 8'h00);
        wr(8'h05, 8'h20);
        tx_length <= 8'($urandom);
        start_frame();
        t = 8'($urandom);
        send_tx(t);
        repeat (3) @(posedge clock);
        check_val(card.heard[$-2], 8'hF0, "sb");
        check_val(card.heard[$-1], tx_length, "len");
        check_val(card.heard[$], t, "data");
        fifo_q.delete();
        card.send(8'hF0, 1'b1, 1'b0);
        card.send(8'hF0, 1'b0, 1'b0);
        card.send(t, 1'b0, 1'b0);
        repeat (2) @(posedge clock);
        check_val(8'(fifo_q.size()), 8'h02, "rx count");
        check_val(fifo_q[0], 8'hF0, "rx second");
        end_frame();
        // Start/stop omission keeps only the last complete byte.
        wr(8'h05, 8'h00);
        wr(8'h06, 8'h01);
        start_frame();
        fifo_q.delete();
        card.send(8'h5A, 1'b1, 1'b0);
        card.send(8'hA5, 1'b0, 1'b1);
        repeat (2) @(posedge clock);
        check_val(8'(fifo_q.size()), 8'h01, "omit count");
        check_val(fifo_q[0], 8'hA5, "omit byte");
        end_frame();
        // The default command clears both settings registers.
        wr(8'h05, 8'hFF);
        wr(8'h06, 8'hFF);
        @(posedge clock);
        set_default <= 1'b1;
        @(posedge clock);
        set_default <= 1'b0;
        rd(8'h05, v); check_val(v, 8'h00, "dflt a");
        rd(8'h06, v); check_val(v, 8'h00, "dflt b");
        conclude();
    end
endmodule
